// [scp_map.svh]
// Offsets, field positions and reset values of the serial control port
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

`define SCP_CFG_ADDR 13'h0000
`define SCP_CFG_LSB_BIT 6
`define SCP_CFG_4W_BIT 7
`define SCP_CFG_RESET 8'h00
`define SCP_STRAP_SPI 3'h0
`define SCP_I2C_ADDR_HI 4'h9
`define SCP_INSTR_BITS 5'h10
`define SCP_CNT_STREAM 2'h3
`define SCP_FIFO_DEPTH 16

`endif

// [scp_pkg.sv]
// Types shared by the serial control port and its write buffer
package scp_pkg;

    typedef enum logic [1:0] {
        SCP_IDLE,
        SCP_INSTR,
        SCP_DATA,
        SCP_HOLD
    } scp_state_t;

    typedef struct packed {
        logic [12:0] addr;
        logic [7:0] data;
    } scp_wr_word_t;

    typedef struct packed {
        scp_state_t state;
        logic resume_data;
        logic [3:0] cnt;
        logic [15:0] shift;
        logic [12:0] addr;
        logic [1:0] left;
        logic stream;
        logic rd;
        logic lsb;
        logic rd_pend;
        logic [7:0] tx;
        logic bit_out;
    } scp_ctl_t;

    // Bytes in the payload; zero stands for streaming
    function automatic logic [1:0] scp_bytes(input logic [1:0] count);
        scp_bytes = (count == 2'h3) ? 2'h0 : 2'(count + 2'h1);
    endfunction : scp_bytes

endpackage : scp_pkg

// [scp_spi_port.sv]
// Serial control port: strap-selected SPI slave with its write buffer
`timescale 1ns/1ps
`default_nettype none
`include "scp_map.svh"


////////////////////////////////////////////////////////////////////////////////
module scp_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = `SCP_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic do_push;
    logic do_pop;

    assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[AW-1:0]];
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;

    always_comb
    begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (do_push)
        begin
            next_wr_ptr = wr_ptr + (AW+1)'(1);
        end
        if (do_pop)
        begin
            next_rd_ptr = rd_ptr + (AW+1)'(1);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage carries no reset; only the pointers decide what is valid
    always_ff @(posedge ref_clk)
    begin
        if (do_push)
        begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule : scp_fifo

////////////////////////////////////////////////////////////////////////////////
module scp_spi_port #(
    parameter int FIFO_DEPTH = `SCP_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic protocol_strap_bit0,
    input wire logic protocol_strap_bit1,
    input wire logic protocol_strap_bit2,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    output logic sdo_out,
    output logic sdo_oe,
    output logic spi_active,
    output logic i2c_active,
    output logic [6:0] i2c_slave_addr,
    output logic cfg_lsb_first,
    output logic cfg_four_wire,
    output scp_pkg::scp_wr_word_t wr_word,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic wr_overrun,
    output logic rd_req,
    output logic [12:0] rd_addr,
    input wire logic [7:0] rd_data
);
    logic [2:0] strap_m;
    logic [2:0] strap_q;
    logic [2:0] pin_m;
    logic [2:0] pin_q;
    logic [2:0] pin_p;
    logic strap_done;
    logic next_strap_done;
    logic spi_sel;
    logic next_spi_sel;
    logic [2:0] strap_low;
    logic [2:0] next_strap_low;
    scp_pkg::scp_ctl_t ctl;
    scp_pkg::scp_ctl_t next_ctl;
    logic [7:0] cfg;
    logic [7:0] next_cfg;
    logic next_overrun;
    logic push_valid;
    logic push_ready;
    scp_pkg::scp_wr_word_t push_word;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic cs_high;
    logic sdio_bit;
    logic [15:0] instr_sh;
    logic [7:0] byte_sh;
    logic [12:0] step_addr;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: sclk, cs_n, sdio_in and the straps
    always_ff @(posedge ref_clk)
    begin
        pin_m <= {sclk, cs_n, sdio_in};
        pin_q <= pin_m;
        pin_p <= pin_q;
        strap_m <= {protocol_strap_bit2, protocol_strap_bit1, protocol_strap_bit0};
        strap_q <= strap_m;
    end

    assign sclk_rise = pin_q[2] && !pin_p[2];
    assign sclk_fall = !pin_q[2] && pin_p[2];
    assign cs_high = pin_q[1];
    assign cs_fall = !pin_q[1] && pin_p[1];
    assign cs_rise = pin_q[1] && !pin_p[1];
    assign sdio_bit = pin_q[0];

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture, once per reset
    always_comb
    begin
        next_strap_done = 1'b1;
        next_spi_sel = spi_sel;
        next_strap_low = strap_low;
        if (!strap_done)
        begin
            next_spi_sel = strap_q == `SCP_STRAP_SPI;
            next_strap_low = strap_q;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            strap_done <= 1'b0;
            spi_sel <= 1'b0;
            strap_low <= 3'h0;
        end
        else
        begin
            strap_done <= next_strap_done;
            spi_sel <= next_spi_sel;
            strap_low <= next_strap_low;
        end
    end

    assign spi_active = strap_done && spi_sel;
    assign i2c_active = strap_done && !spi_sel;
    assign i2c_slave_addr = {`SCP_I2C_ADDR_HI, strap_low};

    ////////////////////////////////////////////////////////////////////////////
    // Transfer engine and the in-port configuration register
    assign instr_sh = ctl.lsb ? {sdio_bit, ctl.shift[15:1]} : {ctl.shift[14:0], sdio_bit};
    assign byte_sh = ctl.lsb ? {sdio_bit, ctl.shift[7:1]} : {ctl.shift[6:0], sdio_bit};
    assign step_addr = ctl.lsb ? ctl.addr + 13'h0001 : ctl.addr - 13'h0001;

    always_comb
    begin
        next_ctl = ctl;
        next_cfg = cfg;
        next_overrun = wr_overrun;
        push_valid = 1'b0;
        push_word = '{addr: ctl.addr, data: byte_sh};
        if (ctl.rd_pend)
        begin
            next_ctl.tx = (ctl.addr == `SCP_CFG_ADDR) ? cfg : rd_data;
            next_ctl.rd_pend = 1'b0;
        end
        if (!spi_active)
        begin
            next_ctl.state = scp_pkg::SCP_IDLE;
        end
        else if (cs_fall)
        begin
            case (ctl.state)
                scp_pkg::SCP_IDLE:
                begin
                    next_ctl.state = scp_pkg::SCP_INSTR;
                    next_ctl.cnt = 4'h0;
                    next_ctl.lsb = cfg[`SCP_CFG_LSB_BIT];
                end
                scp_pkg::SCP_HOLD:
                begin
                    next_ctl.state = ctl.resume_data ? scp_pkg::SCP_DATA : scp_pkg::SCP_INSTR;
                end
                default:
                begin
                    next_ctl.state = ctl.state;
                end
            endcase
        end
        else if (cs_rise)
        begin
            if (ctl.state == scp_pkg::SCP_INSTR || ctl.state == scp_pkg::SCP_DATA)
            begin
                if (ctl.cnt[2:0] != 3'h0)
                begin
                    next_ctl.state = scp_pkg::SCP_IDLE;
                end
                else if (ctl.state == scp_pkg::SCP_INSTR && ctl.cnt == 4'h0)
                begin
                    next_ctl.state = scp_pkg::SCP_IDLE;
                end
                else if (ctl.state == scp_pkg::SCP_DATA && ctl.stream)
                begin
                    next_ctl.state = scp_pkg::SCP_IDLE;
                end
                else
                begin
                    next_ctl.state = scp_pkg::SCP_HOLD;
                    next_ctl.resume_data = ctl.state == scp_pkg::SCP_DATA;
                end
            end
        end
        else if (sclk_rise && !cs_high)
        begin
            if (ctl.state == scp_pkg::SCP_INSTR)
            begin
                next_ctl.shift = instr_sh;
                next_ctl.cnt = ctl.cnt + 4'h1;
                if (5'(ctl.cnt) == `SCP_INSTR_BITS - 5'h01)
                begin
                    next_ctl.rd = instr_sh[15];
                    next_ctl.left = scp_pkg::scp_bytes(instr_sh[14:13]);
                    next_ctl.stream = instr_sh[14:13] == `SCP_CNT_STREAM;
                    next_ctl.addr = instr_sh[12:0];
                    next_ctl.rd_pend = instr_sh[15];
                    next_ctl.state = scp_pkg::SCP_DATA;
                    next_ctl.cnt = 4'h0;
                end
            end
            else if (ctl.state == scp_pkg::SCP_DATA)
            begin
                next_ctl.shift = {ctl.shift[15:8], byte_sh};
                next_ctl.cnt = {1'b0, ctl.cnt[2:0] + 3'h1};
                if (ctl.cnt[2:0] == 3'h7)
                begin
                    if (!ctl.rd && ctl.addr == `SCP_CFG_ADDR)
                    begin
                        next_cfg = byte_sh;
                    end
                    else if (!ctl.rd)
                    begin
                        push_valid = 1'b1;
                        // Host cannot be stalled: a full buffer loses the byte
                        next_overrun = wr_overrun || !push_ready;
                    end
                    next_ctl.addr = step_addr;
                    next_ctl.left = ctl.left - 2'h1;
                    if (!ctl.stream && ctl.left == 2'h1)
                    begin
                        next_ctl.state = scp_pkg::SCP_IDLE;
                    end
                    else
                    begin
                        next_ctl.rd_pend = ctl.rd;
                    end
                end
            end
        end
        else if (sclk_fall && !cs_high && ctl.state == scp_pkg::SCP_DATA && ctl.rd)
        begin
            next_ctl.bit_out = ctl.lsb ? ctl.tx[0] : ctl.tx[7];
            next_ctl.tx = ctl.lsb ? {1'b0, ctl.tx[7:1]} : {ctl.tx[6:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ctl <= '{state: scp_pkg::SCP_IDLE, default: '0};
            cfg <= `SCP_CFG_RESET;
            wr_overrun <= 1'b0;
        end
        else
        begin
            ctl <= next_ctl;
            cfg <= next_cfg;
            wr_overrun <= next_overrun;
        end
    end

    assign cfg_lsb_first = cfg[`SCP_CFG_LSB_BIT];
    assign cfg_four_wire = cfg[`SCP_CFG_4W_BIT];
    assign rd_req = ctl.rd_pend;
    assign rd_addr = ctl.addr;
    assign sdio_out = ctl.bit_out;
    assign sdo_out = ctl.bit_out;
    assign sdio_oe = (ctl.state == scp_pkg::SCP_DATA) && ctl.rd && !cs_high && !cfg_four_wire;
    assign sdo_oe = (ctl.state == scp_pkg::SCP_DATA) && ctl.rd && !cs_high && cfg_four_wire;

    ////////////////////////////////////////////////////////////////////////////
    // Write buffer toward the register map
    scp_fifo #(
        .WIDTH($bits(scp_pkg::scp_wr_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_data(push_word),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .out_data(wr_word),
        .out_valid(wr_valid),
        .out_ready(wr_ready)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    strap_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        strap_done |=> $stable(spi_active) && $stable(i2c_slave_addr))
        else $error("protocol choice changed after strap capture");

    spi_select_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !strap_done ##1 strap_done |-> spi_active == ($past(strap_q) == 3'h0))
        else $error("protocol select does not follow straps");

    tri_state_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cs_high |-> !sdio_oe && !sdo_oe)
        else $error("data pin driven while select high");

    wire_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sdo_oe |-> cfg_four_wire) and (sdio_oe |-> !cfg_four_wire))
        else $error("read data on wrong pin for wiring mode");

    flush_abort_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        spi_active && cs_rise && ctl.cnt[2:0] != 3'h0 && ctl.state != scp_pkg::SCP_IDLE
        |=> ctl.state == scp_pkg::SCP_IDLE)
        else $error("mid-byte deselect did not end transfer");

    stall_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        spi_active && cs_rise && ctl.state == scp_pkg::SCP_DATA && !ctl.stream
        && ctl.cnt[2:0] == 3'h0 |=> ctl.state == scp_pkg::SCP_HOLD [*2])
        else $error("stall on byte boundary did not hold");

    count_decode_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(ctl.state) == scp_pkg::SCP_INSTR && ctl.state == scp_pkg::SCP_DATA
        |-> ctl.left == ((ctl.shift[14:13] == 2'h3) ? 2'h0 : ctl.shift[14:13] + 2'h1))
        else $error("byte count decoded wrongly");

    addr_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        push_valid |=> ctl.addr == ($past(ctl.lsb) ? $past(ctl.addr) + 13'h0001
        : $past(ctl.addr) - 13'h0001))
        else $error("address did not step in the bit order direction");

    reset_mode_a: assert property (@(posedge ref_clk)
        !rst_n |=> !cfg_lsb_first && !cfg_four_wire)
        else $error("port not in 3-wire MSB-first after reset");

    read_fetch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_req |=> !rd_req)
        else $error("read fetch lasted more than one cycle");

endmodule : scp_spi_port
`default_nettype wire

// [scp_host_model.sv]
// Behavioural SPI host that frames transfers towards the serial control port
`timescale 1ns/1ps
`default_nettype none

module scp_host_model (
    output var logic sclk,
    output var logic cs_n,
    output var logic mosi,
    input wire logic miso
);
    initial
    begin
        sclk = 1'h0;
        cs_n = 1'h1;
        mosi = 1'h0;
    end

    // Select edges sit well clear of clock edges; the clock idles low outside frames
    task automatic select(input logic level);
        #100;
        cs_n = level;
        #100;
        if (level)
            mosi = ~mosi;
    endtask : select

    // Partial counts are how a mid-byte abort is made
    task automatic shift(input logic [7:0] b, input int n, input logic lsb,
                         output logic [7:0] r);
        for (int i = 0; i < n; i++)
        begin
            mosi = lsb ? b[i] : b[7 - i];
            #62.5;
            sclk = 1'h1;
            r = lsb ? {miso, r[7:1]} : {r[6:0], miso};
            #62.5;
            sclk = 1'h0;
        end
    endtask : shift

    task automatic word(input logic [15:0] w, input logic lsb);
        logic [7:0] r;
        shift(lsb ? w[7:0] : w[15:8], 8, lsb, r);
        shift(lsb ? w[15:8] : w[7:0], 8, lsb, r);
    endtask : word
endmodule : scp_host_model

`default_nettype wire

// [testbench.sv]
// Self-checking bench for the serial control port
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam int CYCLE_LIMIT = 40000;
    logic ref_clk;
    logic rst_n;
    logic [2:0] strap;
    logic wr_ready;
    logic four_wire_bus;
    wire sclk;
    wire cs_n;
    wire mosi;
    wire miso;
    wire sdio_line;
    logic sdio_out;
    logic sdio_oe;
    logic sdo_out;
    logic sdo_oe;
    logic spi_active;
    logic i2c_active;
    logic [6:0] i2c_slave_addr;
    logic cfg_lsb_first;
    logic cfg_four_wire;
    scp_pkg::scp_wr_word_t wr_word;
    logic wr_valid;
    logic wr_overrun;
    logic rd_req;
    logic [12:0] rd_addr;
    logic [7:0] rd_data;
    scp_pkg::scp_wr_word_t got[$];
    logic [7:0] rd_bytes[$];
    int bad_count;
    int samples_checked;
    int cycles;

    function automatic logic [7:0] rd_val(input logic [12:0] a);
        rd_val = a[7:0] ^ 8'h5A;
    endfunction : rd_val

    // On a four-wire bus an undriven SDO pin shows the inverse so a wrong pin never reads right
    assign rd_data = rd_val(rd_addr);
    assign sdio_line = sdio_oe ? sdio_out : mosi;
    assign miso = four_wire_bus ? (sdo_oe ? sdo_out : ~sdo_out) : sdio_line;

    scp_spi_port scp_spi_port_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .protocol_strap_bit0(strap[0]), .protocol_strap_bit1(strap[1]),
        .protocol_strap_bit2(strap[2]), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_line),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .spi_active(spi_active), .i2c_active(i2c_active), .i2c_slave_addr(i2c_slave_addr),
        .cfg_lsb_first(cfg_lsb_first), .cfg_four_wire(cfg_four_wire), .wr_word(wr_word),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_overrun(wr_overrun),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data));

    scp_host_model scp_host_model_inst (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

    ////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        cycles++;
        if ((wr_valid & wr_ready) === 1'h1)
            got.push_back(wr_word);
        if (sdio_oe === 1'h1)
            check("sdo_oe", sdo_oe, 32'h0);
        if (cycles == CYCLE_LIMIT)
        begin
            bad_count++;
            stop_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        if (bad_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task automatic pop_wr(input logic [12:0] a, input logic [7:0] d);
        scp_pkg::scp_wr_word_t w;
        w = (got.size() > 0) ? got.pop_front() : 'x;
        check("wr_word", 32'(w), 32'({a, d}));
    endtask : pop_wr

    task automatic do_reset(input logic [2:0] s);
        strap <= s;
        rst_n <= 1'h0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge ref_clk);
    endtask : do_reset

    // Payload byte k carries d0 + k
    task automatic xfer(input logic rw, input logic [1:0] cnt, input logic [12:0] a,
                        input int n, input logic lsb, input logic stall, input logic [7:0] d0);
        logic [7:0] r;
        rd_bytes.delete();
        scp_host_model_inst.select(1'h0);
        scp_host_model_inst.word({rw, cnt, a}, lsb);
        for (int k = 0; k < n; k++)
        begin
            if (stall)
            begin
                scp_host_model_inst.select(1'h1);
                scp_host_model_inst.select(1'h0);
            end
            scp_host_model_inst.shift(d0 + 8'(k), 8, lsb, r);
            rd_bytes.push_back(r);
        end
        scp_host_model_inst.select(1'h1);
    endtask : xfer

    ////////////////////////////////////////////////////////////
    task automatic test_straps();
        for (int s = 1; s < 8; s++)
        begin
            do_reset(3'(s));
            strap <= 3'h0;
            repeat (6) @(posedge ref_clk);
            check("i2c_active", i2c_active, 32'h1);
            check("spi_active", spi_active, 32'h0);
            check("i2c_slave_addr", i2c_slave_addr, {4'h9, 3'(s)});
        end
        do_reset(3'h0);
        check("spi_active", spi_active, 32'h1);
        check("cfg", {cfg_four_wire, cfg_lsb_first}, 32'h0);
        check("oe", {sdio_oe, sdo_oe, wr_valid, wr_overrun}, 32'h0);
    endtask : test_straps

    task automatic test_write_stall();
        xfer(1'h0, 2'h2, 13'h0105, 3, 1'h0, 1'h1, 8'hA0);
        repeat (10) @(posedge ref_clk);
        for (int k = 0; k < 3; k++)
            pop_wr(13'h0105 - 13'(k), 8'hA0 + 8'(k));
    endtask : test_write_stall

    task automatic test_read_3wire();
        xfer(1'h1, 2'h1, 13'h0020, 2, 1'h0, 1'h0, 8'h00);
        check("rd_byte0", rd_bytes[0], rd_val(13'h0020));
        check("rd_byte1", rd_bytes[1], rd_val(13'h001F));
        check("oe_idle", {sdio_oe, sdo_oe}, 32'h0);
    endtask : test_read_3wire

    task automatic test_lsb_4wire();
        xfer(1'h0, 2'h0, 13'h0000, 1, 1'h0, 1'h0, 8'hC0);
        repeat (5) @(posedge ref_clk);
        check("cfg_lsb_first", cfg_lsb_first, 32'h1);
        check("cfg_four_wire", cfg_four_wire, 32'h1);
        check("fifo_level", got.size(), 32'h0);
        four_wire_bus = 1'h1;
        xfer(1'h1, 2'h1, 13'h0030, 2, 1'h1, 1'h0, 8'h00);
        check("rd_byte0", rd_bytes[0], rd_val(13'h0030));
        check("rd_byte1", rd_bytes[1], rd_val(13'h0031));
        xfer(1'h1, 2'h0, 13'h0000, 1, 1'h1, 1'h0, 8'h00);
        check("cfg_read", rd_bytes[0], 32'hC0);
        xfer(1'h0, 2'h3, 13'h0040, 3, 1'h1, 1'h0, 8'hB0);
        repeat (10) @(posedge ref_clk);
        for (int k = 0; k < 3; k++)
            pop_wr(13'h0040 + 13'(k), 8'hB0 + 8'(k));
        xfer(1'h0, 2'h0, 13'h0000, 1, 1'h1, 1'h0, 8'h00);
        four_wire_bus = 1'h0;
        repeat (5) @(posedge ref_clk);
        check("cfg_lsb_first", cfg_lsb_first, 32'h0);
    endtask : test_lsb_4wire

    // A deselect three bits into the byte resumed after a stall lands mid-byte and must flush
    task automatic test_abort();
        logic [7:0] r;
        scp_host_model_inst.select(1'h0);
        scp_host_model_inst.word({1'h0, 2'h2, 13'h0060}, 1'h0);
        scp_host_model_inst.shift(8'h11, 8, 1'h0, r);
        scp_host_model_inst.select(1'h1);
        scp_host_model_inst.select(1'h0);
        scp_host_model_inst.shift(8'hFF, 3, 1'h0, r);
        scp_host_model_inst.select(1'h1);
        xfer(1'h0, 2'h0, 13'h0070, 1, 1'h0, 1'h0, 8'h22);
        repeat (10) @(posedge ref_clk);
        pop_wr(13'h0060, 8'h11);
        pop_wr(13'h0070, 8'h22);
        check("fifo_level", got.size(), 32'h0);
    endtask : test_abort

    task automatic test_fifo_full();
        @(posedge ref_clk);
        wr_ready <= 1'h0;
        xfer(1'h0, 2'h3, 13'h0100, 18, 1'h0, 1'h0, 8'h00);
        @(posedge ref_clk);
        check("wr_overrun", wr_overrun, 32'h1);
        wr_ready <= 1'h1;
        repeat (40) @(posedge ref_clk);
        for (int k = 0; k < 16; k++)
            pop_wr(13'h0100 - 13'(k), 8'(k));
        check("fifo_level", got.size(), 32'h0);
        check("wr_valid", wr_valid, 32'h0);
    endtask : test_fifo_full

    ////////////////////////////////////////////////////////////
    initial
    begin
        rst_n = 1'h0;
        strap = 3'h0;
        wr_ready = 1'h1;
        four_wire_bus = 1'h0;
        bad_count = 0;
        samples_checked = 0;
        cycles = 0;
        @(posedge ref_clk);
        test_straps();
        test_write_stall();
        test_read_3wire();
        test_lsb_4wire();
        test_abort();
        test_fifo_full();
        stop_test();
    end
endmodule : testbench

`default_nettype wire
